// ### logic/aux_gpio_pkg.sv
// Shared constants for the auxiliary pin port: register map, field layout,
// reset values and decoder time bases.
// Assumes a single 40 MHz main clock drives every user of this package.
package aux_gpio_pkg;

   // Pin count; index 0 aux_pin_zero_side_a, 1 aux_pin_one_side_a,
   // 2 aux_pin_zero_side_b, 3 aux_pin_one_side_b
   localparam int NUM_PINS = 4;

   // Register port widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register offsets (word index on the plain register port)
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_OUTPUT = 4'h1;
   localparam logic [3:0] ADDR_READBACK = 4'h2;

   // Config register: one 4-bit slice per pin
   localparam int CFG_STRIDE = 4;
   localparam int CFG_DIR_POS = 0;
   localparam int CFG_FMT_POS = 1;
   localparam int CFG_TB_POS = 2;

   // Readback register: one 2-bit input_level_field per pin
   localparam int RB_STRIDE = 2;

   // Reset values: all pins inputs, static format, fastest time base
   localparam logic [15:0] CONFIG_RST = 16'h0000;
   localparam logic [3:0] OUTPUT_RST = 4'h0;

   // Decoder time base in main-clock cycles per selection code
   localparam logic [10:0] TB_DIV_0 = 11'h001;
   localparam logic [10:0] TB_DIV_1 = 11'h008;
   localparam logic [10:0] TB_DIV_2 = 11'h040;
   localparam logic [10:0] TB_DIV_3 = 11'h400;

   // Width of the high and low duration counters
   localparam int CNT_W = 8;

endpackage

// ### logic/pwm_decode_if.sv
// Carrier between the port top and one pin decoder.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface pwm_decode_if;
   logic pinLevel;          // Synchronised pin level
   logic formatPwm;         // 1: decode PWM, 0: static level
   logic [1:0] timebaseSel; // Decoder time base code
   logic [1:0] level;       // Decoded input_level_field

   // Top side drives the settings and reads the level
   modport ctrl (output pinLevel, output formatPwm, output timebaseSel, input level);
   // Decoder side
   modport dec (input pinLevel, input formatPwm, input timebaseSel, output level);
endinterface

// ### logic/pwm_level_decoder.sv
// One pin's level decoder: static level or four-level PWM duty decode.
// Assumes pinLevel is already synchronised to clk.
`timescale 1ns/1ps
module pwm_level_decoder
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Settings in, level out
   pwm_decode_if.dec port
);

   localparam logic [aux_gpio_pkg::CNT_W-1:0] CNT_MAX = '1;

   logic [10:0] preCnt_q, preCnt_d;       // Time base prescaler
   logic [aux_gpio_pkg::CNT_W-1:0] highCnt_q, highCnt_d; // High duration
   logic [aux_gpio_pkg::CNT_W-1:0] lowCnt_q, lowCnt_d;   // Low duration
   logic prevLevel_q, prevLevel_d;        // Last pin level for edges
   logic [1:0] level_q, level_d;          // Reported level
   logic [10:0] divisor;
   logic tick, rise, fall;
   logic [10:0] fourH, period, twoP, threeP;

   // Time base selection and duty thresholds
   always_comb
   begin
      case (port.timebaseSel)
         2'h0: divisor = aux_gpio_pkg::TB_DIV_0;
         2'h1: divisor = aux_gpio_pkg::TB_DIV_1;
         2'h2: divisor = aux_gpio_pkg::TB_DIV_2;
         default: divisor = aux_gpio_pkg::TB_DIV_3;
      endcase
      tick = (preCnt_q >= divisor - 11'h001);
      rise = port.pinLevel & ~prevLevel_q;
      fall = ~port.pinLevel & prevLevel_q;
      fourH = {1'b0, highCnt_q, 2'h0}; // Four times the high count, padded to the compare width
      period = 11'(highCnt_q) + 11'(lowCnt_q);
      twoP = {period[9:0], 1'b0};
      threeP = 11'(twoP + period);
   end

   // Next state: durations counted in time base units
   always_comb
   begin
      preCnt_d = tick ? 11'h000 : 11'(preCnt_q + 11'h001);
      prevLevel_d = port.pinLevel;
      highCnt_d = highCnt_q;
      lowCnt_d = lowCnt_q;
      level_d = level_q;
      if (tick && port.pinLevel && highCnt_q != CNT_MAX)
      begin
         highCnt_d = highCnt_q + 1'b1;
      end
      if (tick && !port.pinLevel && lowCnt_q != CNT_MAX)
      begin
         lowCnt_d = lowCnt_q + 1'b1;
      end
      if (rise)
      begin
         highCnt_d = '0; // New high phase starts
      end
      if (fall)
      begin
         lowCnt_d = '0; // New low phase starts
      end
      if (!port.formatPwm)
      begin
         level_d = {1'b0, port.pinLevel};
      end
      else if (rise)
      begin
         // Duty quartile of the last high plus the low just ended
         if (fourH < period)
            level_d = 2'h0;
         else if (fourH < twoP)
            level_d = 2'h1;
         else if (fourH < threeP)
            level_d = 2'h2;
         else
            level_d = 2'h3;
      end
      else if (port.pinLevel && highCnt_q == CNT_MAX)
      begin
         level_d = 2'h3; // Stuck high reads as full duty
      end
      else if (!port.pinLevel && lowCnt_q == CNT_MAX)
      begin
         level_d = 2'h0; // Stuck low reads as zero duty
      end
   end

   // Registers only
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         preCnt_q <= 11'h000;
         highCnt_q <= '0;
         lowCnt_q <= '0;
         prevLevel_q <= 1'b0;
         level_q <= 2'h0;
      end
      else
      begin
         preCnt_q <= preCnt_d;
         highCnt_q <= highCnt_d;
         lowCnt_q <= lowCnt_d;
         prevLevel_q <= prevLevel_d;
         level_q <= level_d;
      end
   end

   assign port.level = level_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Static format follows the pin one cycle later
   property p_static_level;
      !port.formatPwm |=> level_q == {1'b0, $past(port.pinLevel)};
   endproperty
   a_static_level: assert property (p_static_level) else $error("static level wrong");

   // Slowest time base: no tick for eight cycles while it stays selected;
   // a switch to a faster base may tick at once, so only code 3 is held to it
   property p_tb_slow;
      (port.timebaseSel == 2'h3 && $stable(port.timebaseSel) && tick)
         |=> (!tick || port.timebaseSel != 2'h3) [*8];
   endproperty
   a_tb_slow: assert property (p_tb_slow) else $error("time base tick too early");

   // PWM level changes only on a rising edge or a saturated count
   property p_pwm_change;
      (port.formatPwm && $past(port.formatPwm) && $changed(level_q))
         |-> $past(rise) || $past(highCnt_q) == CNT_MAX || $past(lowCnt_q) == CNT_MAX;
   endproperty
   a_pwm_change: assert property (p_pwm_change) else $error("pwm level changed without cause");

   // Durations move only on a tick or an edge
   property p_count_tick;
      (!tick && !rise && !fall) |=> $stable(highCnt_q) && $stable(lowCnt_q);
   endproperty
   a_count_tick: assert property (p_count_tick) else $error("count moved without tick");

endmodule

// ### logic/aux_gpio_pwm_decode_port.sv
// Four auxiliary pins: push-pull output or input, static or PWM decoded.
// Assumes a 40 MHz clk, asynchronous pins, and a register master whose
// strobes last one cycle and never overlap.
`timescale 1ns/1ps
module aux_gpio_pwm_decode_port
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [aux_gpio_pkg::ADDR_W-1:0] regAddr,
   input wire logic [aux_gpio_pkg::DATA_W-1:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [aux_gpio_pkg::DATA_W-1:0] regRdata,
   // Auxiliary pins, one bit per pin
   input wire logic [aux_gpio_pkg::NUM_PINS-1:0] pinIn,
   output logic [aux_gpio_pkg::NUM_PINS-1:0] pinOut,
   output logic [aux_gpio_pkg::NUM_PINS-1:0] pinOe
);

   // Software state
   logic [15:0] config_q, config_d;  // Per-pin direction, format, time base
   logic [3:0] outLevel_q, outLevel_d; // output_level_bit per pin
   logic [3:0] pinOe_q, pinOe_d;     // Drive enables
   logic [15:0] rdata_q, rdata_d;    // Read data, valid cycle after read

   // Pin synchroniser; stage one feeds only stage two
   logic [3:0] syncA_q;
   logic [3:0] syncB_q;

   // Decoded levels gathered for readback
   logic [7:0] readback;

   // Decoded write strobes
   logic wrConfig;
   logic wrOutput;

   // Address decode of write strobes
   always_comb
   begin
      wrConfig = regWrite && (regAddr == aux_gpio_pkg::ADDR_CONFIG);
      wrOutput = regWrite && (regAddr == aux_gpio_pkg::ADDR_OUTPUT);
   end

   // Next values of the software registers and drive enables
   always_comb
   begin
      config_d = config_q;
      outLevel_d = outLevel_q;
      if (wrConfig)
      begin
         config_d = regWdata;
      end
      if (wrOutput)
      begin
         outLevel_d = regWdata[3:0];
      end
      // Enable is the direction bit alone: format never touches the output
      // path, since this port has no PWM generator
      for (int i = 0; i < aux_gpio_pkg::NUM_PINS; i++)
      begin
         pinOe_d[i] = config_d[i*aux_gpio_pkg::CFG_STRIDE + aux_gpio_pkg::CFG_DIR_POS];
      end
   end

   // Read data; unmapped offsets answer zero
   always_comb
   begin
      case (regAddr)
         aux_gpio_pkg::ADDR_CONFIG: rdata_d = config_q;
         aux_gpio_pkg::ADDR_OUTPUT: rdata_d = {12'h000, outLevel_q};
         aux_gpio_pkg::ADDR_READBACK: rdata_d = {8'h00, readback};
         default: rdata_d = 16'h0000;
      endcase
      if (!regRead)
      begin
         rdata_d = 16'h0000; // Data stand only in the cycle after a read
      end
   end

   // Register stage for software state and outputs
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         config_q <= aux_gpio_pkg::CONFIG_RST;
         outLevel_q <= aux_gpio_pkg::OUTPUT_RST;
         pinOe_q <= 4'h0;
         rdata_q <= 16'h0000;
      end
      else
      begin
         config_q <= config_d;
         outLevel_q <= outLevel_d;
         pinOe_q <= pinOe_d;
         rdata_q <= rdata_d;
      end
   end

   // Two-flop synchroniser for the asynchronous pins
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         syncA_q <= 4'h0;
         syncB_q <= 4'h0;
      end
      else
      begin
         syncA_q <= pinIn;
         syncB_q <= syncA_q;
      end
   end

   // Push-pull drive: the level bit goes out whatever its value
   assign pinOut = outLevel_q;
   assign pinOe = pinOe_q;
   assign regRdata = rdata_q;

   // One decoder per pin; the pin is sampled even while driven, so the
   // readback shows what really sits on the wire
   genvar g;
   generate
      for (g = 0; g < aux_gpio_pkg::NUM_PINS; g++)
      begin : pinDec
         pwm_decode_if decIf ();

         assign decIf.pinLevel = syncB_q[g];
         assign decIf.formatPwm = config_q[g*aux_gpio_pkg::CFG_STRIDE + aux_gpio_pkg::CFG_FMT_POS];
         assign decIf.timebaseSel =
            config_q[g*aux_gpio_pkg::CFG_STRIDE + aux_gpio_pkg::CFG_TB_POS +: 2];

         // Readback settles one full period after the one that changed
         pwm_level_decoder decoder
         (
            .clk(clk),
            .reset_n(reset_n),
            .port(decIf.dec)
         );

         assign readback[g*aux_gpio_pkg::RB_STRIDE +: 2] = decIf.level;
      end
   endgenerate

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   // Write then readback sequences
   sequence s_cfg_write;
      wrConfig;
   endsequence

   sequence s_out_write;
      wrOutput;
   endsequence

   // Direction bits reach the enables one cycle after the write
   property p_dir_write;
      logic [15:0] w;
      (s_cfg_write, w = regWdata) |=> pinOe == {w[12], w[8], w[4], w[0]};
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction not applied");

   // Written level appears on the pins one cycle later
   property p_level_write;
      logic [3:0] w;
      (s_out_write, w = regWdata[3:0]) |=> pinOut == w;
   endproperty
   a_level_write: assert property (p_level_write) else $error("output level not applied");

   // Without an output write the driven level is static
   property p_static_drive;
      !wrOutput |=> $stable(pinOut);
   endproperty
   a_static_drive: assert property (p_static_drive) else $error("driven level moved");

   // Enables change only after a config write, format bits alone leave them
   property p_oe_source;
      !wrConfig |=> $stable(pinOe);
   endproperty
   a_oe_source: assert property (p_oe_source) else $error("enable changed without write");

   // Readback read returns the decoded levels of the read cycle
   property p_readback;
      (regRead && regAddr == aux_gpio_pkg::ADDR_READBACK) |=> regRdata == {8'h00, $past(readback)};
   endproperty
   a_readback: assert property (p_readback) else $error("readback data wrong");

   // Read data only stand in the cycle after a read
   property p_rdata_idle;
      !regRead |=> regRdata == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");

endmodule

// ### tb/aux_pin_partner.sv
// Model of the external devices wired to the four auxiliary pins.
// Assumes the port drives its pins push-pull whenever pinOe is high.
`timescale 1ns/1ps
module aux_pin_partner
(
   // Clock
   input wire logic clk,
   // Port side of the pins
   input wire logic [3:0] pinOut,
   input wire logic [3:0] pinOe,
   // Bench controls
   input wire logic [3:0] extLevel,
   input wire logic [3:0] pwmSel,
   input wire logic [15:0] highCycles,
   input wire logic [15:0] lowCycles,
   // Resolved pin wires
   output logic [3:0] pinWire
);
   logic [15:0] phaseQ = 16'h0000; // Position within the source period
   logic wave; // Source PWM level

   // Period starts with the low time; lengths are whole decoder ticks, never faster than the decoder
   always @(posedge clk)
   begin
      phaseQ <= (phaseQ + 16'h0001 >= highCycles + lowCycles) ? 16'h0000 : phaseQ + 16'h0001;
   end
   assign wave = (phaseQ >= lowCycles);

   // The port wins where it drives, so both levels reach the wire; else the source drives
   assign pinWire = (pinOe & pinOut) | (~pinOe & ((pwmSel & {4{wave}}) | (~pwmSel & extLevel)));
endmodule

// ### tb/test_aux_gpio_pwm_decode_port.sv
// Self-checking bench for the auxiliary pin port.
// Assumes the register port answers reads one cycle later and never stalls.
`timescale 1ns/1ps
module test_aux_gpio_pwm_decode_port;
   logic clk = 1'b0; // 40 MHz main clock
   logic reset_n = 1'b0; // Held low for 20 cycles
   logic [3:0] regAddr = 4'h0; // Register port, driven by the tasks
   logic [15:0] regWdata = 16'h0000;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [15:0] regRdata;
   logic [3:0] pinIn; // Resolved pin wires
   logic [3:0] pinOut;
   logic [3:0] pinOe;
   logic [3:0] extLevel = 4'h0; // Static level of the external source
   logic [3:0] pwmSel = 4'h0; // Pins fed with the PWM wave
   logic [15:0] highCycles = 16'h0001;
   logic [15:0] lowCycles = 16'h0001;
   int nFail = 0; // Mismatches
   int checked = 0; // Comparisons

   always #12.5 clk = ~clk;

   aux_gpio_pwm_decode_port aux_gpio_pwm_decode_port_i
   (
      .clk(clk),
      .reset_n(reset_n),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regWrite(regWrite),
      .regRead(regRead),
      .regRdata(regRdata),
      .pinIn(pinIn),
      .pinOut(pinOut),
      .pinOe(pinOe)
   );

   aux_pin_partner aux_pin_partner_i
   (
      .clk(clk),
      .pinOut(pinOut),
      .pinOe(pinOe),
      .extLevel(extLevel),
      .pwmSel(pwmSel),
      .highCycles(highCycles),
      .lowCycles(lowCycles),
      .pinWire(pinIn)
   );

   // Compare and report
   task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write strobe
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   // One-cycle read strobe; data stand only in the following cycle
   task rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      chk("readData", regRdata, exp);
   endtask

   // Static readback: each field is {0, wire level}
   function automatic logic [15:0] rbOf(input logic [3:0] w);
      logic [15:0] r;
      r = 16'h0000;
      for (int i = 0; i < 4; i++)
      begin
         r[i*aux_gpio_pkg::RB_STRIDE] = w[i];
      end
      return r;
   endfunction

   // Counts, verdict and end of run
   task stop_test;
      $display("Comparisons %0d, mismatches %0d", checked, nFail);
      if (nFail == 0 && checked > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Cuts a hang short; counts as a mismatch
   initial
   begin
      repeat (80000) @(posedge clk);
      nFail++;
      stop_test;
   end

   initial
   begin
      int k;
      logic [15:0] tick;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      // Reset state: all pins listen
      rd(aux_gpio_pkg::ADDR_CONFIG, aux_gpio_pkg::CONFIG_RST);
      rd(aux_gpio_pkg::ADDR_OUTPUT, {12'h000, aux_gpio_pkg::OUTPUT_RST});
      chk("pinOe", {12'h000, pinOe}, 16'h0000);
      rd(4'hf, 16'h0000);
      // Static inputs; a write to the read-only readback must not matter
      for (k = 5; k <= 10; k += 5)
      begin
         extLevel <= k[3:0];
         wr(aux_gpio_pkg::ADDR_READBACK, 16'hffff);
         repeat (5) @(posedge clk);
         rd(aux_gpio_pkg::ADDR_READBACK, rbOf(k[3:0]));
      end
      // Only pin one drives; an unmapped write is ignored
      extLevel <= 4'h0;
      wr(aux_gpio_pkg::ADDR_CONFIG, 16'h0010);
      wr(aux_gpio_pkg::ADDR_OUTPUT, 16'h000f);
      wr(4'h3, 16'hffff);
      repeat (5) @(posedge clk);
      chk("pinOe", {12'h000, pinOe}, 16'h0002);
      rd(aux_gpio_pkg::ADDR_CONFIG, 16'h0010);
      rd(aux_gpio_pkg::ADDR_READBACK, 16'h0004);
      // All outputs against an opposing source: both levels must win
      wr(aux_gpio_pkg::ADDR_CONFIG, 16'h1111);
      for (k = 5; k <= 10; k += 5)
      begin
         wr(aux_gpio_pkg::ADDR_OUTPUT, {12'h000, k[3:0]});
         extLevel <= ~k[3:0];
         repeat (5) @(posedge clk);
         chk("pinOut", {12'h000, pinOut}, {12'h000, k[3:0]});
         rd(aux_gpio_pkg::ADDR_READBACK, rbOf(k[3:0]));
      end
      // PWM format on outputs still drives a steady level
      wr(aux_gpio_pkg::ADDR_CONFIG, 16'h3333);
      repeat (40)
      begin
         @(posedge clk);
         #1;
         chk("pinOut", {12'h000, pinOut}, 16'h000a);
      end
      // Held pins saturate the PWM counters: steady high reads 3, steady low 0
      repeat (260) @(posedge clk);
      rd(aux_gpio_pkg::ADDR_READBACK, 16'h00cc);
      // Mid-run reset while driving: every pin falls back to listening
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk("pinOe", {12'h000, pinOe}, 16'h0000);
      chk("pinOut", {12'h000, pinOut}, {12'h000, aux_gpio_pkg::OUTPUT_RST});
      reset_n <= 1'b1;
      rd(aux_gpio_pkg::ADDR_CONFIG, aux_gpio_pkg::CONFIG_RST);
      // Restore the level that pins one and three drive below
      wr(aux_gpio_pkg::ADDR_OUTPUT, 16'h000a);
      // PWM decode: pins 0 and 2 decode, pins 1 and 3 drive high
      pwmSel <= 4'hf;
      for (k = 0; k < 4; k++)
      begin
         tick = {5'h00, k == 0 ? aux_gpio_pkg::TB_DIV_0 : k == 1 ? aux_gpio_pkg::TB_DIV_1 :
                 k == 2 ? aux_gpio_pkg::TB_DIV_2 : aux_gpio_pkg::TB_DIV_3};
         // Duty (2+4k)/16 sits mid-band of level k
         highCycles <= tick * (16'h0002 + 16'h0004 * k[15:0]);
         lowCycles <= tick * (16'h000e - 16'h0004 * k[15:0]);
         // Pin two uses a faster decoder than pin zero for k above 0 and the same one at k 0, still not slower than the source
         wr(aux_gpio_pkg::ADDR_CONFIG, {4'h1, (k == 0) ? 2'b00 : 2'(k - 1), 2'b10, 4'h1, k[1:0], 2'b10});
         repeat (48 * int'(tick) + 10) @(posedge clk);
         rd(aux_gpio_pkg::ADDR_READBACK, {8'h00, 2'b01, k[1:0], 2'b01, k[1:0]});
      end
      stop_test;
   end
endmodule
